//--- common/ntad_alu_if.sv
`timescale 1ns/1ps
interface ntad_alu_if;
	import ntad_pkg::*;
	ntad_op_e op;
	ntad_nib_t s1;
	ntad_nib_t s2;
	logic c_in;
	ntad_nib_t res;
	logic f_we;
	logic f_val;
	logic c_we;
	logic c_val;
	modport core (output op, s1, s2, c_in,
		input res, f_we, f_val, c_we, c_val);
	modport alu (input op, s1, s2, c_in,
		output res, f_we, f_val, c_we, c_val);
endinterface : ntad_alu_if

//--- common/ntad_pkg.sv
package ntad_pkg;
	// Register codes shared by the index prefixes and the default operands.
	localparam logic [3:0] CODE_WORK = 4'h0;
	localparam logic [3:0] CODE_STATUS = 4'h1;
	localparam logic [3:0] CODE_LOW_PTR = 4'h2;
	localparam logic [3:0] CODE_RAM = 4'h3;
	localparam logic [3:0] CODE_IN0 = 4'h4;
	localparam logic [3:0] CODE_NULL = 4'h5;
	localparam logic [3:0] CODE_IO0 = 4'h6;
	localparam logic [3:0] CODE_IO1 = 4'h7;
	localparam logic [3:0] CODE_OUT1 = 4'h8;
	localparam logic [3:0] CODE_OUT0 = 4'h9;
	localparam logic [3:0] CODE_HIGH_PTR = 4'hA;
	localparam logic [3:0] CODE_UNUSED = 4'hB;
	localparam logic [3:0] CODE_SHARED = 4'hC;
	localparam logic [3:0] CODE_OUT2 = 4'hD;
	localparam logic [3:0] CODE_IN1 = 4'hE;
	localparam logic [3:0] CODE_INPUT2 = 4'hF;
	// Full opcodes of the fixed instructions.
	localparam logic [7:0] OPC_LOAD_MEM = 8'h26;
	localparam logic [7:0] OPC_LOAD_WORK = 8'h2B;
	localparam logic [7:0] OPC_STORE = 8'h24;
	localparam logic [7:0] OPC_LOAD_TEST = 8'h2A;
	localparam logic [7:0] OPC_INVERT = 8'h1F;
	localparam logic [7:0] OPC_NEGATE = 8'h39;
	localparam logic [7:0] OPC_ADD = 8'h2D;
	localparam logic [7:0] OPC_ADD_CARRY = 8'h35;
	// Upper nibbles of the immediate instructions.
	localparam logic [3:0] OPH_LOAD_IMM = 4'h6;
	localparam logic [3:0] OPH_LOAD_IMM_LOW = 4'h7;
	// Reset values.
	localparam logic [3:0] NIBBLE_RESET = 4'h0;
	localparam logic FLAG_RESET = 1'b0;
	// Operations carried out by the arithmetic unit.
	typedef enum {
		ALU_NONE, ALU_PASS, ALU_TEST, ALU_IMM, ALU_INV, ALU_NEG, ALU_ADD,
		ALU_ADC
	} ntad_op_e;
	typedef logic [3:0] ntad_nib_t;
endpackage : ntad_pkg

//--- rtl/ntad_alu.sv
`timescale 1ns/1ps
module ntad_alu (
	ntad_alu_if.alu bus
);
	import ntad_pkg::*;

	logic [4:0] sum;

	// The sum carries one spare bit so the carry out is seen directly.
	always_comb begin
		sum = 5'h00;
		bus.res = bus.s1;
		bus.f_we = 1'b0;
		bus.f_val = 1'b0;
		bus.c_we = 1'b0;
		bus.c_val = 1'b0;
		case (bus.op)
			ALU_PASS: begin
				bus.res = bus.s1;
			end
			ALU_TEST: begin
				bus.f_we = 1'b1;
				bus.f_val = (bus.s1 == 4'h0);
			end
			ALU_IMM: begin
				bus.res = bus.s2;
			end
			ALU_INV: begin
				bus.res = ~bus.s1;
			end
			ALU_NEG: begin
				sum = {1'b0, ~bus.s1} + 5'h01;
				bus.res = sum[3:0];
				bus.f_we = 1'b1;
				bus.f_val = sum[4];
			end
			ALU_ADD: begin
				sum = {1'b0, bus.s1} + {1'b0, bus.s2};
				bus.res = sum[3:0];
				bus.f_we = 1'b1;
				bus.f_val = sum[4];
			end
			ALU_ADC: begin
				sum = {1'b0, bus.s1} + {1'b0, bus.s2} + {4'h0, bus.c_in};
				bus.res = sum[3:0];
				bus.f_we = 1'b1;
				bus.f_val = sum[4];
				bus.c_we = 1'b1;
				bus.c_val = sum[4];
			end
			default: begin
				bus.res = bus.s1;
			end
		endcase
	end
endmodule : ntad_alu

//--- rtl/ntad_core.sv
`timescale 1ns/1ps
// What this block does
// - Code C: I/O two or output three
// - Load work register from addressed RAM
// - Work register onto itself, no flags
// - Store work register into addressed RAM
// - Load and test sets branch on zero
// - Immediate nibble into work register
// - Immediate nibble into low pointer
// - Branch flag by test, negate, add and ADC; carry only ADC
// - Invert work register, flags untouched
// - Negate; branch flag set when zero
// - Add RAM; branch flag is carry
// - Add RAM and carry; both flags
// - Every instruction completes in one cycle
// - All data paths are four bits
// - Two operands: register plus RAM
// - Codes zero to seven select fixed registers
// - Memory prefix addresses page zero words
module ntad_core #(
	parameter int RAM_DEPTH = 128,
	parameter bit LARGE_VARIANT = 1'b1
) (
	input wire logic CLK,
	input wire logic RESET,
	input wire logic INSTR_VALID,
	input wire logic [7:0] OPCODE,
	input wire logic SRC_IDX_VALID,
	input wire ntad_pkg::ntad_nib_t SRC_CODE,
	input wire logic DST_IDX_VALID,
	input wire ntad_pkg::ntad_nib_t DST_CODE,
	input wire logic MEM_IDX_VALID,
	input wire ntad_pkg::ntad_nib_t MEM_IDX_ADDR,
	input wire ntad_pkg::ntad_nib_t IN_PORT0,
	input wire ntad_pkg::ntad_nib_t IN_PORT1,
	input wire ntad_pkg::ntad_nib_t IN_PORT2,
	input wire ntad_pkg::ntad_nib_t IO_PORT0_IN,
	input wire ntad_pkg::ntad_nib_t IO_PORT1_IN,
	input wire ntad_pkg::ntad_nib_t IO_PORT2_IN,
	output logic [3:0] IO_PORT0_OUT,
	output logic [3:0] IO_PORT1_OUT,
	output logic [3:0] IO_PORT2_OUT,
	output logic [3:0] OUT_PORT0,
	output logic [3:0] OUT_PORT1,
	output logic [3:0] OUT_PORT2,
	output logic [3:0] OUT_PORT3,
	output logic [3:0] WORK_REG,
	output logic [3:0] STATUS_REG,
	output logic [3:0] LOW_PTR,
	output logic [3:0] HIGH_PTR,
	output logic FLAG_F,
	output logic FLAG_C
);
	import ntad_pkg::*;

	localparam int RAM_AW = $clog2(RAM_DEPTH);

	// The pointer pair addresses at most 256 nibbles.
	if (RAM_DEPTH < 16 || RAM_DEPTH > 256 || (1 << RAM_AW) != RAM_DEPTH)
	begin : g_bad_depth
		$error("RAM_DEPTH must be a power of two from 16 to 256");
	end

	ntad_alu_if alu_bus ();

	ntad_nib_t work_reg, status_reg, low_reg, high_reg;
	ntad_nib_t io0_reg, io1_reg, bidir2_reg;
	ntad_nib_t out0_reg, out1_reg, out2_reg, out3_reg;
	logic flag_f_reg, flag_c_reg;
	ntad_nib_t mem [RAM_DEPTH];
	logic [7:0] full_addr;
	logic [RAM_AW-1:0] ram_addr;
	ntad_nib_t ram_rd, src_val, imm;
	ntad_nib_t src_code, dst_code, def_src, def_dst;
	ntad_op_e op;
	logic wr_en;

	////////////////////////////////////////////////////////////////////
	// Decode: unindexed instructions use their fixed source and target.
	always_comb begin
		op = ALU_NONE;
		def_src = CODE_WORK;
		def_dst = CODE_WORK;
		case (OPCODE)
			OPC_LOAD_MEM: begin
				op = ALU_PASS;
				def_src = CODE_RAM;
			end
			OPC_LOAD_WORK: op = ALU_PASS;
			OPC_STORE: begin
				op = ALU_PASS;
				def_dst = CODE_RAM;
			end
			OPC_LOAD_TEST: op = ALU_TEST;
			OPC_INVERT: op = ALU_INV;
			OPC_NEGATE: op = ALU_NEG;
			OPC_ADD: op = ALU_ADD;
			OPC_ADD_CARRY: op = ALU_ADC;
			default: begin
				if (OPCODE[7:4] == OPH_LOAD_IMM) begin
					op = ALU_IMM;
				end else if (OPCODE[7:4] == OPH_LOAD_IMM_LOW) begin
					op = ALU_IMM;
					def_dst = CODE_LOW_PTR;
				end
			end
		endcase
	end

	// A prefix replaces the fixed operand; the caller keeps prefixes to
	// those each instruction lists, since others give undefined results.
	assign src_code = SRC_IDX_VALID ? SRC_CODE : def_src;
	assign dst_code = DST_IDX_VALID ? DST_CODE : def_dst;
	assign wr_en = INSTR_VALID && (op != ALU_NONE);
	assign imm = OPCODE[3:0];

	// The memory prefix uses page zero and leaves the pointers alone.
	assign full_addr = MEM_IDX_VALID ? {4'h0, MEM_IDX_ADDR}
		: {high_reg, low_reg};
	assign ram_addr = full_addr[RAM_AW-1:0];
	assign ram_rd = mem[ram_addr];

	////////////////////////////////////////////////////////////////////
	// Source selector; inputs and I/O pins are read live.
	always_comb begin
		case (src_code)
			CODE_WORK: src_val = work_reg;
			CODE_STATUS: src_val = status_reg;
			CODE_LOW_PTR: src_val = low_reg;
			CODE_RAM: src_val = ram_rd;
			CODE_IN0: src_val = IN_PORT0;
			CODE_IO0: src_val = IO_PORT0_IN;
			CODE_IO1: src_val = IO_PORT1_IN;
			CODE_OUT1: src_val = out1_reg;
			CODE_OUT0: src_val = out0_reg;
			CODE_HIGH_PTR: src_val = high_reg;
			CODE_SHARED: src_val = LARGE_VARIANT ? out3_reg
				: IO_PORT2_IN;
			CODE_OUT2: src_val = out2_reg;
			CODE_IN1: src_val = IN_PORT1;
			CODE_INPUT2: src_val = IN_PORT2;
			default: src_val = 4'h0; // Null and unused codes read zero.
		endcase
	end

	assign alu_bus.op = op;
	assign alu_bus.s1 = src_val;
	assign alu_bus.s2 = (op == ALU_IMM) ? imm : ram_rd;
	assign alu_bus.c_in = flag_c_reg;

	ntad_alu u_alu (
		.bus(alu_bus)
	);

	////////////////////////////////////////////////////////////////////
	// Destination selector: core registers.
	always_ff @(posedge CLK) begin
		if (RESET) begin
			work_reg <= NIBBLE_RESET;
			status_reg <= NIBBLE_RESET;
			low_reg <= NIBBLE_RESET;
			high_reg <= NIBBLE_RESET;
		end else if (wr_en) begin
			if (dst_code == CODE_WORK) work_reg <= alu_bus.res;
			if (dst_code == CODE_STATUS) status_reg <= alu_bus.res;
			if (dst_code == CODE_LOW_PTR) low_reg <= alu_bus.res;
			if (dst_code == CODE_HIGH_PTR) high_reg <= alu_bus.res;
		end
	end

	// Destination selector: port latches. Code C lands on one latch only,
	// so the evaluator's I/O two can stand in for output three.
	always_ff @(posedge CLK) begin
		if (RESET) begin
			io0_reg <= NIBBLE_RESET;
			io1_reg <= NIBBLE_RESET;
			bidir2_reg <= NIBBLE_RESET;
			out0_reg <= NIBBLE_RESET;
			out1_reg <= NIBBLE_RESET;
			out2_reg <= NIBBLE_RESET;
			out3_reg <= NIBBLE_RESET;
		end else if (wr_en) begin
			if (dst_code == CODE_IO0) io0_reg <= alu_bus.res;
			if (dst_code == CODE_IO1) io1_reg <= alu_bus.res;
			if (dst_code == CODE_OUT0) out0_reg <= alu_bus.res;
			if (dst_code == CODE_OUT1) out1_reg <= alu_bus.res;
			if (dst_code == CODE_OUT2) out2_reg <= alu_bus.res;
			if (dst_code == CODE_SHARED) begin
				if (LARGE_VARIANT) out3_reg <= alu_bus.res;
				else bidir2_reg <= alu_bus.res;
			end
		end
	end

	// RAM writes go to the same address the source side read from.
	always_ff @(posedge CLK) begin
		if (wr_en && dst_code == CODE_RAM) begin
			mem[ram_addr] <= alu_bus.res;
		end
	end

	// Condition bits change only when the unit asks for it.
	always_ff @(posedge CLK) begin
		if (RESET) begin
			flag_f_reg <= FLAG_RESET;
			flag_c_reg <= FLAG_RESET;
		end else if (INSTR_VALID) begin
			if (alu_bus.f_we) flag_f_reg <= alu_bus.f_val;
			if (alu_bus.c_we) flag_c_reg <= alu_bus.c_val;
		end
	end

	assign IO_PORT0_OUT = io0_reg;
	assign IO_PORT1_OUT = io1_reg;
	assign IO_PORT2_OUT = bidir2_reg;
	assign OUT_PORT0 = out0_reg;
	assign OUT_PORT1 = out1_reg;
	assign OUT_PORT2 = out2_reg;
	assign OUT_PORT3 = out3_reg;
	assign WORK_REG = work_reg;
	assign STATUS_REG = status_reg;
	assign LOW_PTR = low_reg;
	assign HIGH_PTR = high_reg;
	assign FLAG_F = flag_f_reg;
	assign FLAG_C = flag_c_reg;

	////////////////////////////////////////////////////////////////////
	// Checks on unindexed instructions and on the memory prefix, one cycle after issue.
	logic plain;
	assign plain = INSTR_VALID && !SRC_IDX_VALID && !DST_IDX_VALID
		&& !MEM_IDX_VALID;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (RESET);

	property p_load_mem;
		plain && OPCODE == OPC_LOAD_MEM |=> work_reg == $past(ram_rd)
			&& $stable(flag_f_reg) && $stable(flag_c_reg);
	endproperty
	a_load_mem: assert property (p_load_mem)
		else $error("load from memory wrong");

	property p_load_work;
		plain && OPCODE == OPC_LOAD_WORK |=> $stable(work_reg)
			&& $stable(flag_f_reg) && $stable(flag_c_reg);
	endproperty
	a_load_work: assert property (p_load_work)
		else $error("load work register changed state");

	property p_store;
		plain && OPCODE == OPC_STORE |=> mem[$past(ram_addr)] ==
			$past(work_reg) && $stable(flag_f_reg);
	endproperty
	a_store: assert property (p_store)
		else $error("store did not reach RAM");

	property p_test;
		plain && OPCODE == OPC_LOAD_TEST |=> flag_f_reg ==
			($past(work_reg) == 4'h0) && $stable(flag_c_reg);
	endproperty
	a_test: assert property (p_test)
		else $error("load and test flag wrong");

	property p_imm_low;
		plain && OPCODE[7:4] == OPH_LOAD_IMM_LOW |=> low_reg ==
			$past(OPCODE[3:0]) && $stable(work_reg) && $stable(flag_f_reg);
	endproperty
	a_imm_low: assert property (p_imm_low)
		else $error("low pointer immediate wrong");

	property p_invert;
		plain && OPCODE == OPC_INVERT |=> work_reg == ~$past(work_reg)
			&& $stable(flag_f_reg);
	endproperty
	a_invert: assert property (p_invert)
		else $error("invert wrong");

	property p_negate;
		plain && OPCODE == OPC_NEGATE |=> work_reg == 4'h0 - $past(work_reg)
			&& flag_f_reg == ($past(work_reg) == 4'h0);
	endproperty
	a_negate: assert property (p_negate)
		else $error("negate wrong");

	property p_add;
		plain && OPCODE == OPC_ADD |=> {flag_f_reg, work_reg} ==
			{1'b0, $past(work_reg)} + {1'b0, $past(ram_rd)}
			&& $stable(flag_c_reg);
	endproperty
	a_add: assert property (p_add)
		else $error("add wrong");

	property p_adc;
		plain && OPCODE == OPC_ADD_CARRY |=> flag_c_reg == flag_f_reg
			&& {flag_c_reg, work_reg} == {1'b0, $past(work_reg)}
			+ {1'b0, $past(ram_rd)} + {4'h0, $past(flag_c_reg)};
	endproperty
	a_adc: assert property (p_adc)
		else $error("add with carry wrong");

	property p_page_zero;
		INSTR_VALID && MEM_IDX_VALID && !DST_IDX_VALID
			&& OPCODE[7:4] != OPH_LOAD_IMM_LOW |=> $stable(low_reg)
			&& $stable(high_reg);
	endproperty
	a_page_zero: assert property (p_page_zero)
		else $error("memory prefix moved the pointers");
endmodule : ntad_core

//--- verif/ntad_core_tb_top.sv
`timescale 1ns/1ps
module ntad_core_tb_top;
	import ntad_pkg::*;
	typedef struct {
		ntad_nib_t rg [16];
		logic f;
		logic c;
	} ntad_exp_s;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic instr_valid = 1'b0;
	logic [7:0] opcode = 8'h00;
	logic src_idx_valid = 1'b0;
	ntad_nib_t src_code = 4'h0;
	logic dst_idx_valid = 1'b0;
	ntad_nib_t dst_code = 4'h0;
	logic mem_idx_valid = 1'b0;
	ntad_nib_t mem_idx_addr = 4'h0;
	ntad_nib_t in0 = 4'h0;
	ntad_nib_t in1 = 4'h0;
	ntad_nib_t inp2 = 4'h0;
	ntad_nib_t io0 = 4'h0;
	ntad_nib_t io1 = 4'h0;
	ntad_nib_t bio2 = 4'h0;
	logic [3:0] io0_o, io1_o, bio2_o, out0, out1, out2, out3;
	logic [3:0] work, status, low, high;
	logic flag_f, flag_c;
	int failures = 0;
	int compares = 0;
	int unsigned seed;
	ntad_exp_s notes [$];
	ntad_exp_s mdl = '{default: '0};
	ntad_nib_t ram [128];
	logic took = 1'b0;
	logic [7:0] ops [10] = '{OPC_LOAD_MEM, OPC_LOAD_WORK, OPC_STORE,
		OPC_LOAD_TEST, OPC_INVERT, OPC_NEGATE, OPC_ADD, OPC_ADD_CARRY,
		8'h60, 8'h70};

	////////////////////////////////////////////////////////////////////////
	// Clock at 100 MHz.
	always #5 clk = ~clk;

	ntad_core #(.RAM_DEPTH(128), .LARGE_VARIANT(1'b1)) uut (
		.CLK(clk), .RESET(reset), .INSTR_VALID(instr_valid),
		.OPCODE(opcode), .SRC_IDX_VALID(src_idx_valid),
		.SRC_CODE(src_code), .DST_IDX_VALID(dst_idx_valid),
		.DST_CODE(dst_code), .MEM_IDX_VALID(mem_idx_valid),
		.MEM_IDX_ADDR(mem_idx_addr), .IN_PORT0(in0), .IN_PORT1(in1),
		.IN_PORT2(inp2), .IO_PORT0_IN(io0), .IO_PORT1_IN(io1),
		.IO_PORT2_IN(bio2), .IO_PORT0_OUT(io0_o), .IO_PORT1_OUT(io1_o),
		.IO_PORT2_OUT(bio2_o), .OUT_PORT0(out0), .OUT_PORT1(out1),
		.OUT_PORT2(out2), .OUT_PORT3(out3), .WORK_REG(work),
		.STATUS_REG(status), .LOW_PTR(low), .HIGH_PTR(high),
		.FLAG_F(flag_f), .FLAG_C(flag_c)
	);

	////////////////////////////////////////////////////////////////////////
	// One comparison; an unknown matches only an identical unknown.
	task check(input logic [3:0] seen, input logic [3:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask : check

	// The single place where the run ends.
	task test_done;
		$display("Comparisons %0d, mismatches %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : test_done

	// Drives one instruction for one cycle and notes the predicted state.
	// The model is kept here so expectations never come from the design.
	task automatic issue(input logic [7:0] opc, input logic [4:0] s,
		input logic [4:0] d, input logic [4:0] m);
		logic [6:0] a;
		logic [3:0] sc;
		logic [3:0] dc;
		logic [3:0] v;
		logic [3:0] r;
		logic cy;
		@(negedge clk);
		instr_valid = 1'b1;
		opcode = opc;
		{src_idx_valid, src_code} = s;
		{dst_idx_valid, dst_code} = d;
		{mem_idx_valid, mem_idx_addr} = m;
		{in0, in1, inp2, io0, io1, bio2} = 24'($urandom);
		a = {mdl.rg[CODE_HIGH_PTR][2:0], mdl.rg[CODE_LOW_PTR]};
		if (m[4])
			a = {3'h0, m[3:0]};
		sc = (opc == OPC_LOAD_MEM) ? CODE_RAM : CODE_WORK;
		if (s[4])
			sc = s[3:0];
		dc = (opc == OPC_STORE) ? CODE_RAM : CODE_WORK;
		if (opc[7:4] == OPH_LOAD_IMM_LOW)
			dc = CODE_LOW_PTR;
		if (d[4])
			dc = d[3:0];
		case (sc)
			CODE_RAM: v = ram[a];
			CODE_IN0: v = in0;
			CODE_NULL: v = 4'h0;
			CODE_IO0: v = io0;
			CODE_IO1: v = io1;
			CODE_IN1: v = in1;
			CODE_INPUT2: v = inp2;
			default: v = mdl.rg[sc];
		endcase
		r = v;
		case (opc)
			OPC_LOAD_TEST: mdl.f = (v == 4'h0);
			OPC_INVERT: r = ~v;
			OPC_NEGATE: begin
				r = 4'h0 - v;
				mdl.f = (v == 4'h0);
			end
			OPC_ADD: begin
				{cy, r} = {1'b0, v} + {1'b0, ram[a]};
				mdl.f = cy;
			end
			OPC_ADD_CARRY: begin
				{cy, r} = {1'b0, v} + {1'b0, ram[a]} + {4'h0, mdl.c};
				mdl.f = cy;
				mdl.c = cy;
			end
			default: begin
				if (opc[7:5] == 3'h3)
					r = opc[3:0];
			end
		endcase
		case (dc)
			CODE_RAM: ram[a] = r;
			CODE_IN0, CODE_NULL, CODE_UNUSED, CODE_IN1, CODE_INPUT2: ;
			default: mdl.rg[dc] = r;
		endcase
		notes.push_back(mdl);
	endtask : issue

	////////////////////////////////////////////////////////////////////////
	// Marks the edges at which an instruction was taken.
	always @(posedge clk) begin
		took <= instr_valid && !reset;
	end

	// Results must stand one cycle after the instruction, so each taken
	// edge is matched against the oldest note at the following falling edge.
	always @(negedge clk) begin : monitor
		ntad_exp_s e;
		if (took) begin
			if (notes.size() == 0) begin
				check(4'h1, 4'h0);
			end else begin
				e = notes.pop_front();
				check(work, e.rg[CODE_WORK]);
				check(status, e.rg[CODE_STATUS]);
				check(low, e.rg[CODE_LOW_PTR]);
				check(high, e.rg[CODE_HIGH_PTR]);
				check(io0_o, e.rg[CODE_IO0]);
				check(io1_o, e.rg[CODE_IO1]);
				check(bio2_o, 4'h0);
				check(out0, e.rg[CODE_OUT0]);
				check(out1, e.rg[CODE_OUT1]);
				check(out2, e.rg[CODE_OUT2]);
				check(out3, e.rg[CODE_SHARED]);
				check({3'h0, flag_f}, {3'h0, e.f});
				check({3'h0, flag_c}, {3'h0, e.c});
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Main sequence: fill RAM, then random back-to-back instructions.
	initial begin : main
		logic [7:0] opc;
		logic [4:0] s;
		logic [4:0] d;
		logic [4:0] m;
		int k;
		seed = $urandom(18940);
		repeat (12) @(posedge clk);
		@(negedge clk);
		reset = 1'b0;
		// Every word is written first, since RAM powers up unknown.
		for (int i = 0; i < 128; i++) begin
			issue({OPH_LOAD_IMM, 1'b0, i[6:4]}, 5'h00, 5'h1A, 5'h00);
			issue({OPH_LOAD_IMM_LOW, i[3:0]}, 5'h00, 5'h00, 5'h00);
			issue({OPH_LOAD_IMM, 4'($urandom)}, 5'h00, 5'h00, 5'h00);
			issue(OPC_STORE, 5'h00, 5'h00, 5'h00);
		end
		// Only prefixes that each instruction accepts are applied.
		for (int n = 0; n < 800; n++) begin
			k = $urandom_range(9);
			opc = ops[k];
			if (opc[7:5] == 3'h3)
				opc[3:0] = 4'($urandom);
			// Every code is drawn, so refused targets and null reads occur.
			s = {1'b0, 4'($urandom)};
			d = {1'b0, 4'($urandom)};
			m = {1'($urandom), 4'($urandom)};
			if ($urandom_range(1) == 1 && opc != OPC_LOAD_MEM &&
				opc[7:5] != 3'h3)
				s[4] = 1'b1;
			if ($urandom_range(1) == 1 && opc != OPC_STORE)
				d[4] = 1'b1;
			issue(opc, s, d, m);
		end
		@(negedge clk);
		instr_valid = 1'b0;
		// Bounded drain of the outstanding notes.
		for (k = 0; k < 20 && notes.size() > 0; k++)
			@(negedge clk);
		// A note left over means a result never appeared.
		check({3'h0, notes.size() != 0}, 4'h0);
		test_done();
	end
endmodule : ntad_core_tb_top
